// ### design/e1_rx_error_counters_defines.vh
`ifndef E1_RX_ERROR_COUNTERS_DEFINES_VH
`define E1_RX_ERROR_COUNTERS_DEFINES_VH

// register bus shape
`define ADDR_WIDTH 16
`define DATA_WIDTH 8

// register byte addresses
`define FRAME_ALIGN_ERR_COUNT_HI_ADDR 16'h0902
`define FRAME_ALIGN_ERR_COUNT_LO_ADDR 16'h0903
`define SEVERE_FRAME_ERR_COUNT_ADDR 16'h0904
`define CRC4_SYNC_ERR_COUNT_HI_ADDR 16'h0905
`define CRC4_SYNC_ERR_COUNT_LO_ADDR 16'h0906
`define IRQ_STATUS_ADDR 16'h0910
`define IRQ_MASK_ADDR 16'h0911

// counter widths
`define WIDE_COUNT_WIDTH 16
`define SEVERE_COUNT_WIDTH 8

// reset values
`define WIDE_COUNT_RESET 16'h0000
`define SEVERE_COUNT_RESET 8'h00
`define IRQ_STATUS_RESET 4'h0
`define IRQ_MASK_RESET 4'h0
`define READ_DATA_RESET 8'h00
`define UNMAPPED_READ_VALUE 8'h00

// interrupt status / mask bit positions
`define IRQ_WIDTH 4
`define IRQ_BIT_FRAME_ALIGN_ERR 0
`define IRQ_BIT_SEVERE_FRAME 1
`define IRQ_BIT_CRC4_SYNC_ERR 2
`define IRQ_BIT_SATURATED 3

// consecutive errored alignment words that make one severe frame event
`define SEVERE_RUN_LENGTH 2'h2

`endif

// ### design/e1_rx_error_counters.v
`include "e1_rx_error_counters_defines.vh"
`default_nettype none

module e1_rx_error_counters #(
  parameter WIDE_WIDTH = `WIDE_COUNT_WIDTH,
  parameter SEVERE_WIDTH = `SEVERE_COUNT_WIDTH
) (
  // clock and reset
  input wire mclk,
  input wire reset_n,
  // error and alignment-word-ok events from the receive framer, one-cycle pulses
  input wire frame_align_err,
  input wire fas_word_ok,
  input wire loss_of_frame,
  input wire crc4_sync_err,
  // register port
  input wire [`ADDR_WIDTH-1:0] reg_addr,
  input wire [`DATA_WIDTH-1:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [`DATA_WIDTH-1:0] reg_rdata,
  // interrupt
  output wire irq
);

  localparam [WIDE_WIDTH-1:0] WIDE_MAX = {WIDE_WIDTH{1'b1}};
  localparam [SEVERE_WIDTH-1:0] SEVERE_MAX = {SEVERE_WIDTH{1'b1}};
  localparam [WIDE_WIDTH-1:0] WIDE_ONE = {{(WIDE_WIDTH-1){1'b0}}, 1'b1};
  localparam [SEVERE_WIDTH-1:0] SEVERE_ONE = {{(SEVERE_WIDTH-1){1'b0}}, 1'b1};

  // per wide channel: 0 = frame alignment errors, 1 = CRC-4 sync bit errors
  wire [1:0] wide_event;
  wire [2*WIDE_WIDTH-1:0] wide_count_flat;
  wire [2*WIDE_WIDTH-1:0] wide_snap_flat;
  wire [1:0] wide_pending;
  wire [1:0] wide_sat_hit;
  wire [2*`DATA_WIDTH-1:0] wide_hi_flat;
  wire [2*`DATA_WIDTH-1:0] wide_lo_flat;

  assign wide_event[0] = frame_align_err;
  assign wide_event[1] = crc4_sync_err;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_wide
      wire [`ADDR_WIDTH-1:0] hi_addr;
      wire [`ADDR_WIDTH-1:0] lo_addr;
      wire read_hi;
      wire read_lo;
      wire clear_pair;
      reg [WIDE_WIDTH-1:0] count;
      reg [WIDE_WIDTH-1:0] snap;
      reg pending;
      reg [WIDE_WIDTH-1:0] base;
      reg [WIDE_WIDTH-1:0] next_count;

      assign hi_addr = (ch == 0) ? `FRAME_ALIGN_ERR_COUNT_HI_ADDR : `CRC4_SYNC_ERR_COUNT_HI_ADDR;
      assign lo_addr = (ch == 0) ? `FRAME_ALIGN_ERR_COUNT_LO_ADDR : `CRC4_SYNC_ERR_COUNT_LO_ADDR;
      assign read_hi = reg_read && (reg_addr == hi_addr);
      assign read_lo = reg_read && (reg_addr == lo_addr);
      assign clear_pair = read_lo && pending;

      // the pair clears only what was reported, so events after the upper read survive
      always @* begin
        base = clear_pair ? (count - snap) : count;
        if (wide_event[ch] && (base != WIDE_MAX)) begin
          next_count = base + WIDE_ONE;
        end else begin
          next_count = base;
        end
      end

      always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          count <= `WIDE_COUNT_RESET;
          snap <= `WIDE_COUNT_RESET;
          pending <= 1'b0;
        end else begin
          count <= next_count;
          if (read_hi) begin
            snap <= count;
            pending <= 1'b1;
          end else if (read_lo) begin
            pending <= 1'b0;
          end
        end
      end

      assign wide_count_flat[ch*WIDE_WIDTH +: WIDE_WIDTH] = count;
      assign wide_snap_flat[ch*WIDE_WIDTH +: WIDE_WIDTH] = snap;
      assign wide_pending[ch] = pending;
      assign wide_sat_hit[ch] = (next_count == WIDE_MAX) && (count != WIDE_MAX);

      // byte views handed to the read mux
      wire [`DATA_WIDTH-1:0] hi_byte;
      wire [`DATA_WIDTH-1:0] lo_byte;
      assign hi_byte = count[WIDE_WIDTH-1:WIDE_WIDTH-`DATA_WIDTH];
      assign lo_byte = pending ? snap[`DATA_WIDTH-1:0] : count[`DATA_WIDTH-1:0];
      assign wide_hi_flat[ch*`DATA_WIDTH +: `DATA_WIDTH] = hi_byte;
      assign wide_lo_flat[ch*`DATA_WIDTH +: `DATA_WIDTH] = lo_byte;
    end
  endgenerate

  wire [`DATA_WIDTH-1:0] fae_hi_byte;
  wire [`DATA_WIDTH-1:0] fae_lo_byte;
  wire [`DATA_WIDTH-1:0] crc_hi_byte;
  wire [`DATA_WIDTH-1:0] crc_lo_byte;
  assign fae_hi_byte = wide_hi_flat[`DATA_WIDTH-1:0];
  assign fae_lo_byte = wide_lo_flat[`DATA_WIDTH-1:0];
  assign crc_hi_byte = wide_hi_flat[2*`DATA_WIDTH-1:`DATA_WIDTH];
  assign crc_lo_byte = wide_lo_flat[2*`DATA_WIDTH-1:`DATA_WIDTH];

  wire [WIDE_WIDTH-1:0] fae_count;
  wire [WIDE_WIDTH-1:0] fae_snap;
  wire [WIDE_WIDTH-1:0] crc_count;
  wire [WIDE_WIDTH-1:0] crc_snap;
  assign fae_count = wide_count_flat[WIDE_WIDTH-1:0];
  assign fae_snap = wide_snap_flat[WIDE_WIDTH-1:0];
  assign crc_count = wide_count_flat[2*WIDE_WIDTH-1:WIDE_WIDTH];
  assign crc_snap = wide_snap_flat[2*WIDE_WIDTH-1:WIDE_WIDTH];

  // severe frame detection: run of errored alignment words
  reg [1:0] err_run;
  reg [1:0] next_err_run;
  reg severe_event;

  always @* begin
    severe_event = 1'b0;
    next_err_run = err_run;
    if (loss_of_frame) begin
      next_err_run = 2'h0;
    end else if (frame_align_err) begin
      if (err_run + 2'h1 == `SEVERE_RUN_LENGTH) begin
        severe_event = 1'b1;
        next_err_run = 2'h0;
      end else begin
        next_err_run = err_run + 2'h1;
      end
    end else if (fas_word_ok) begin
      next_err_run = 2'h0;
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      err_run <= 2'h0;
    end else begin
      err_run <= next_err_run;
    end
  end

  // severe frame counter, cleared by its own read
  reg [SEVERE_WIDTH-1:0] severe_count;
  reg [SEVERE_WIDTH-1:0] severe_base;
  reg [SEVERE_WIDTH-1:0] next_severe_count;
  wire read_severe;
  assign read_severe = reg_read && (reg_addr == `SEVERE_FRAME_ERR_COUNT_ADDR);

  always @* begin
    severe_base = read_severe ? `SEVERE_COUNT_RESET : severe_count;
    if (severe_event && (severe_base != SEVERE_MAX)) begin
      next_severe_count = severe_base + SEVERE_ONE;
    end else begin
      next_severe_count = severe_base;
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      severe_count <= `SEVERE_COUNT_RESET;
    end else begin
      severe_count <= next_severe_count;
    end
  end

  wire severe_sat_hit;
  assign severe_sat_hit = (next_severe_count == SEVERE_MAX) && (severe_count != SEVERE_MAX);

  // interrupt status (write one to clear, new event wins) and mask
  localparam [`IRQ_WIDTH-1:0] IRQ_STATUS_INIT = `IRQ_STATUS_RESET;
  wire [`IRQ_WIDTH-1:0] irq_status;
  reg [`IRQ_WIDTH-1:0] irq_mask;
  reg [`IRQ_WIDTH-1:0] irq_set;
  reg [`IRQ_WIDTH-1:0] irq_clear;

  always @* begin
    irq_set = {`IRQ_WIDTH{1'b0}};
    irq_set[`IRQ_BIT_FRAME_ALIGN_ERR] = frame_align_err;
    irq_set[`IRQ_BIT_SEVERE_FRAME] = severe_event;
    irq_set[`IRQ_BIT_CRC4_SYNC_ERR] = crc4_sync_err;
    irq_set[`IRQ_BIT_SATURATED] = (|wide_sat_hit) | severe_sat_hit;
    if (reg_write && (reg_addr == `IRQ_STATUS_ADDR)) begin
      irq_clear = reg_wdata[`IRQ_WIDTH-1:0];
    end else begin
      irq_clear = {`IRQ_WIDTH{1'b0}};
    end
  end

  // one sticky bit per event source; a set in the clearing cycle wins
  genvar ib;
  generate
    for (ib = 0; ib < `IRQ_WIDTH; ib = ib + 1) begin : g_irq_bit
      reg status_bit;
      always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          status_bit <= IRQ_STATUS_INIT[ib];
        end else if (irq_set[ib]) begin
          status_bit <= 1'b1;
        end else if (irq_clear[ib]) begin
          status_bit <= 1'b0;
        end
      end
      assign irq_status[ib] = status_bit;
    end
  endgenerate

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq_mask <= `IRQ_MASK_RESET;
    end else begin
      if (reg_write && (reg_addr == `IRQ_MASK_ADDR)) begin
        irq_mask <= reg_wdata[`IRQ_WIDTH-1:0];
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  // read data: valid the cycle after the strobe only
  reg [`DATA_WIDTH-1:0] next_rdata;

  always @* begin
    next_rdata = `UNMAPPED_READ_VALUE;
    case (reg_addr)
      `FRAME_ALIGN_ERR_COUNT_HI_ADDR: begin
        next_rdata = fae_hi_byte;
      end
      `FRAME_ALIGN_ERR_COUNT_LO_ADDR: begin
        next_rdata = fae_lo_byte;
      end
      `SEVERE_FRAME_ERR_COUNT_ADDR: begin
        next_rdata = severe_count;
      end
      `CRC4_SYNC_ERR_COUNT_HI_ADDR: begin
        next_rdata = crc_hi_byte;
      end
      `CRC4_SYNC_ERR_COUNT_LO_ADDR: begin
        next_rdata = crc_lo_byte;
      end
      `IRQ_STATUS_ADDR: begin
        next_rdata = {{(`DATA_WIDTH-`IRQ_WIDTH){1'b0}}, irq_status};
      end
      `IRQ_MASK_ADDR: begin
        next_rdata = {{(`DATA_WIDTH-`IRQ_WIDTH){1'b0}}, irq_mask};
      end
      default: begin
        next_rdata = `UNMAPPED_READ_VALUE;
      end
    endcase
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= `READ_DATA_RESET;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= `READ_DATA_RESET;
    end
  end

endmodule // e1_rx_error_counters

`default_nettype wire

// ### tb/e1_rx_error_counters_assertions.sv
`default_nettype none
module e1_rx_error_counters_assertions (
  // clock, reset, framer events
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic frame_align_err,
  input wire logic fas_word_ok,
  input wire logic loss_of_frame,
  input wire logic crc4_sync_err,
  // register port and interrupt
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  wire fa = frame_align_err;
  wire cr = crc4_sync_err;
  wire fh = reg_read && reg_addr == 16'h0902;
  wire fl = reg_read && reg_addr == 16'h0903;
  wire sv = reg_read && reg_addr == 16'h0904;
  wire ch = reg_read && reg_addr == 16'h0905;
  wire cl = reg_read && reg_addr == 16'h0906;
  property p_idle;
    !$past(reg_read) |-> reg_rdata == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("read data not zero outside a read");
  property p_sev_clr;
    sv && !fa ##1 !fa ##1 sv |=> reg_rdata == 8'h00;
  endproperty
  a_sev_clr: assert property (p_sev_clr) else $error("severe count not cleared by read");
  property p_fpair;
    fh && !fa ##1 !fa ##1 fl && !fa ##1 !fa ##1 fh |=> reg_rdata == 8'h00;
  endproperty
  a_fpair: assert property (p_fpair) else $error("alignment count not cleared by pair");
  property p_cpair;
    ch && !cr ##1 !cr ##1 cl && !cr ##1 !cr ##1 ch |=> reg_rdata == 8'h00;
  endproperty
  a_cpair: assert property (p_cpair) else $error("crc count not cleared by pair");
  property p_fhold;
    fh && !fa ##1 !fa ##1 fh |=> reg_rdata == $past(reg_rdata, 2);
  endproperty
  a_fhold: assert property (p_fhold) else $error("upper read alone changed count");
  property p_unmap;
    reg_read && reg_addr == 16'h0A00 |=> reg_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_irq_rise;
    $rose(irq) |-> $past(fa || cr || reg_write);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
  property p_mask0;
    reg_write && reg_addr == 16'h0911 && reg_wdata == 8'h00 |=> !irq;
  endproperty
  a_mask0: assert property (p_mask0) else $error("irq high with mask zero");
  c_pair: cover property (fh ##2 fl);
  c_sev: cover property (sv);
  c_irq: cover property ($rose(irq));
endmodule // e1_rx_error_counters_assertions
bind e1_rx_error_counters e1_rx_error_counters_assertions chk (.mclk(mclk), .reset_n(reset_n),
  .frame_align_err(frame_align_err), .fas_word_ok(fas_word_ok), .loss_of_frame(loss_of_frame),
  .crc4_sync_err(crc4_sync_err), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq));
`default_nettype wire

// ### tb/framer_model.sv
`default_nettype none
module framer_model (
  // control from the bench
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [1:0] kind,
  input wire logic [9:0] n,
  // event pulses and burst busy flag
  output logic frame_align_err,
  output logic fas_word_ok,
  output logic crc4_sync_err,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] left;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) left <= 10'h000;
    else if (start) left <= n;
    else if (left != 10'h000) left <= left - 10'h001;
  end
  // one pulse per cycle of a burst, one event each
  assign busy = left != 10'h000;
  assign frame_align_err = busy && kind == 2'h0;
  assign fas_word_ok = busy && kind == 2'h1;
  assign crc4_sync_err = busy && kind == 2'h2;
endmodule // framer_model
`default_nettype wire

// ### tb/e1_rx_error_counters_tb.sv
`default_nettype none
module e1_rx_error_counters_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, reset_n = 0, start = 0, loss_of_frame = 0, reg_write = 0, reg_read = 0;
  logic [1:0] kind = 2'h0;
  logic [9:0] n = 10'h000;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  wire [7:0] reg_rdata;
  wire frame_align_err, fas_word_ok, crc4_sync_err, busy, irq;
  int err_count = 0, n_tests = 0, cyc = 0;
  e1_rx_error_counters uut (.mclk(mclk), .reset_n(reset_n), .frame_align_err(frame_align_err),
    .fas_word_ok(fas_word_ok), .loss_of_frame(loss_of_frame), .crc4_sync_err(crc4_sync_err),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .irq(irq));
  framer_model fm (.mclk(mclk), .reset_n(reset_n), .start(start), .kind(kind), .n(n),
    .frame_align_err(frame_align_err), .fas_word_ok(fas_word_ok), .crc4_sync_err(crc4_sync_err), .busy(busy));
  initial forever #50 mclk = ~mclk;
  always @(posedge mclk) if (++cyc == 3000) begin
    err_count++;
    conclude();
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_read <= 1;
    reg_addr <= a;
    @(posedge mclk);
    reg_read <= 0;
    @(negedge mclk);
    chk($sformatf("reg %h", a), reg_rdata, exp);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic exp_irq);
    @(posedge mclk);
    reg_write <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_write <= 0;
    @(negedge mclk);
    chk("irq", {7'h00, irq}, {7'h00, exp_irq});
  endtask
  task automatic fire(input logic [1:0] k, input logic [9:0] m);
    @(posedge mclk);
    start <= 1;
    kind <= k;
    n <= m;
    @(posedge mclk);
    start <= 0;
    @(negedge mclk);
    while (busy) @(negedge mclk);
  endtask
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    reset_n <= 1;
    for (int i = 0; i < 6; i++) rd(16'h0902 + i * (i < 5 ? 1 : 62), 8'h00);
    $display("reset test done");
    fire(2'h0, 10'd3);
    rd(16'h0902, 8'h00);
    rd(16'h0902, 8'h00);
    rd(16'h0903, 8'h03);
    rd(16'h0902, 8'h00);
    rd(16'h0903, 8'h00);
    rd(16'h0904, 8'h01);
    rd(16'h0904, 8'h00);
    @(posedge mclk) loss_of_frame <= 1;
    fire(2'h0, 10'd2);
    @(posedge mclk) loss_of_frame <= 0;
    fire(2'h0, 10'd1);
    fire(2'h1, 10'd1);
    fire(2'h0, 10'd1);
    rd(16'h0904, 8'h00);
    rd(16'h0902, 8'h00);
    rd(16'h0903, 8'h04);
    $display("alignment test done");
    fire(2'h2, 10'd300);
    rd(16'h0905, 8'h01);
    fire(2'h2, 10'd2);
    rd(16'h0906, 8'h2C);
    rd(16'h0905, 8'h00);
    rd(16'h0906, 8'h02);
    rd(16'h0905, 8'h00);
    rd(16'h0906, 8'h00);
    $display("crc test done");
    wr(16'h0911, 8'h0F, 1'b1);
    rd(16'h0911, 8'h0F);
    wr(16'h0910, 8'hFF, 1'b0);
    wr(16'h0911, 8'h01, 1'b0);
    fire(2'h0, 10'd1);
    chk("irq", {7'h00, irq}, 8'h01);
    wr(16'h0911, 8'h00, 1'b0);
    $display("interrupt test done");
    fire(2'h0, 10'd514);
    rd(16'h0904, 8'hFF);
    rd(16'h0910, 8'h0B);
    rd(16'h0902, 8'h02);
    rd(16'h0903, 8'h03);
    $display("saturation test done");
    conclude();
  end
endmodule // e1_rx_error_counters_tb
`default_nettype wire
